// ==== logic/ldcr_defs.vh ====
// constants for the led driver configuration register bank
// Overview of operation
// - drv3 bit 13: one full, zero 40%
// - drv3 bits 6..4: edge rate, 0 slowest
// - drv3 bits 3..0: coarse current code
// - peak equals coarse times fine times scale
// - scale factor is 0.4 plus 0.6 times bit
// - drv1 bit 13: same strength encoding
// - drv1 bits 6..4: edge rate code
`ifndef LDCR_DEFS_VH
`define LDCR_DEFS_VH
`define LDCR_ADDR_DRV3 8'h22
`define LDCR_ADDR_DRV1 8'h23
`define LDCR_CFG_RESET 16'h3000
`define LDCR_STRENGTH_BIT 13
`define LDCR_RATE_HI 6
`define LDCR_RATE_LO 4
`define LDCR_COARSE_HI 3
`define LDCR_COARSE_LO 0
`define LDCR_I2C_ADDR 7'h40
`define LDCR_COARSE_BASE 30'h0000_0af0
`define LDCR_COARSE_STEP 30'h0000_060a
`define LDCR_FINE_BASE 30'h0000_02c6
`define LDCR_FINE_STEP 30'h0000_0018
`define LDCR_SCALE_BASE 30'h0000_0004
`define LDCR_SCALE_STEP 30'h0000_0006
`endif

// ==== logic/ldcr_sync.v ====
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ldcr_sync #(
    parameter WIDTH = 2
) (
    input wire clk_in,
    input wire srst_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always @(posedge clk_in)
            begin
                if (srst_in)
                begin
                    stage1_reg[i] <= 1'b1;
                    stage2_reg[i] <= 1'b1;
                end
                else
                begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate
    assign sync_out = stage2_reg;
endmodule

// ==== logic/ldcr_top.v ====
// led driver configuration registers behind an i2c slave port
`timescale 1ns/1ps
`include "ldcr_defs.vh"
module ldcr_top #(
    parameter [6:0] DEV_ADDR = `LDCR_I2C_ADDR
) (
    input wire clk_in,
    input wire srst_in,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_out,
    input wire [4:0] drv3_fine_current_in,
    input wire [4:0] drv1_fine_current_in,
    output wire drv3_strength_select_out,
    output wire [2:0] drv3_edge_rate_out,
    output wire [3:0] drv3_coarse_current_out,
    output wire drv1_strength_select_out,
    output wire [2:0] drv1_edge_rate_out,
    output wire [3:0] drv1_coarse_current_out,
    output reg [29:0] drv3_peak_target_out,
    output reg [29:0] drv1_peak_target_out
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_DEV = 3'h1;
    localparam [2:0] S_REG = 3'h2;
    localparam [2:0] S_WR = 3'h3;
    localparam [2:0] S_RD = 3'h4;

    wire [1:0] pins_sync;
    wire scl_s;
    wire sda_s;
    reg scl_prev_reg;
    reg sda_prev_reg;
    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] tx_shift_reg;
    reg [7:0] ptr_reg;
    reg [7:0] msb_hold_reg;
    reg [15:0] tx_word_reg;
    reg hi_reg;
    reg tx_active_reg;
    reg oe_reg;
    reg [15:0] cfg3_reg;
    reg [15:0] cfg1_reg;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [7:0] rx_byte;
    wire [7:0] tx_byte;
    wire [29:0] coarse3_w;
    wire [29:0] fine3_w;
    wire [29:0] scale3_w;
    wire [29:0] coarse1_w;
    wire [29:0] fine1_w;
    wire [29:0] scale1_w;

    // read mux shared by first fetch and address increment
    function [15:0] reg_read;
        input [7:0] addr;
        begin
            if (addr == `LDCR_ADDR_DRV3)
                reg_read = cfg3_reg;
            else if (addr == `LDCR_ADDR_DRV1)
                reg_read = cfg1_reg;
            else
                reg_read = 16'h0000;
        end
    endfunction

    ldcr_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    assign rx_byte = shift_reg;
    assign tx_byte = hi_reg ? tx_word_reg[15:8] : tx_word_reg[7:0];
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_reg;

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            state_reg <= S_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            msb_hold_reg <= 8'h00;
            tx_word_reg <= 16'h0000;
            hi_reg <= 1'b1;
            tx_active_reg <= 1'b0;
            oe_reg <= 1'b0;
            cfg3_reg <= `LDCR_CFG_RESET;
            cfg1_reg <= `LDCR_CFG_RESET;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            if (start_det)
            begin
                state_reg <= S_DEV;
                // the start's own scl fall wraps this to zero
                bit_cnt_reg <= 4'hf;
                oe_reg <= 1'b0;
                tx_active_reg <= 1'b0;
            end
            else if (stop_det)
            begin
                state_reg <= S_IDLE;
                oe_reg <= 1'b0;
                tx_active_reg <= 1'b0;
            end
            else if (state_reg != S_IDLE)
            begin
                if (scl_rise)
                begin
                    if (bit_cnt_reg < 4'h8)
                        shift_reg <= {shift_reg[6:0], sda_s};
                    else if (state_reg == S_RD && tx_active_reg)
                    begin
                        if (sda_s)
                        begin
                            state_reg <= S_IDLE;
                            tx_active_reg <= 1'b0;
                        end
                        else if (hi_reg)
                            hi_reg <= 1'b0;
                        else
                        begin
                            hi_reg <= 1'b1;
                            ptr_reg <= ptr_reg + 8'h01;
                            tx_word_reg <= reg_read(ptr_reg + 8'h01);
                        end
                    end
                end
                else if (scl_fall)
                begin
                    if (bit_cnt_reg == 4'h8)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == S_RD)
                        begin
                            tx_shift_reg <= tx_byte;
                            oe_reg <= ~tx_byte[7];
                            tx_active_reg <= 1'b1;
                        end
                        else
                            oe_reg <= 1'b0;
                    end
                    else if (bit_cnt_reg == 4'h7)
                    begin
                        bit_cnt_reg <= 4'h8;
                        oe_reg <= 1'b1;
                        case (state_reg)
                            S_DEV:
                            begin
                                if (rx_byte[7:1] == DEV_ADDR)
                                begin
                                    hi_reg <= 1'b1;
                                    if (rx_byte[0])
                                    begin
                                        state_reg <= S_RD;
                                        tx_word_reg <= reg_read(ptr_reg);
                                    end
                                    else
                                        state_reg <= S_REG;
                                end
                                else
                                begin
                                    state_reg <= S_IDLE;
                                    oe_reg <= 1'b0;
                                end
                            end
                            S_REG:
                            begin
                                ptr_reg <= rx_byte;
                                hi_reg <= 1'b1;
                                state_reg <= S_WR;
                            end
                            S_WR:
                            begin
                                if (hi_reg)
                                begin
                                    msb_hold_reg <= rx_byte;
                                    hi_reg <= 1'b0;
                                end
                                else
                                begin
                                    hi_reg <= 1'b1;
                                    ptr_reg <= ptr_reg + 8'h01;
                                    if (ptr_reg == `LDCR_ADDR_DRV3)
                                        cfg3_reg <= {msb_hold_reg, rx_byte};
                                    if (ptr_reg == `LDCR_ADDR_DRV1)
                                        cfg1_reg <= {msb_hold_reg, rx_byte};
                                end
                            end
                            S_RD:
                                oe_reg <= 1'b0;
                            default:
                            begin
                                state_reg <= S_IDLE;
                                oe_reg <= 1'b0;
                            end
                        endcase
                    end
                    else
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (state_reg == S_RD)
                        begin
                            oe_reg <= ~tx_shift_reg[6];
                            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                        end
                    end
                end
            end
        end
    end

    // last data bit of a read byte: release for master acknowledge
    // handled by the bit_cnt 7 branch above, which clears oe in S_RD

    assign drv3_strength_select_out = cfg3_reg[`LDCR_STRENGTH_BIT];
    assign drv3_edge_rate_out = cfg3_reg[`LDCR_RATE_HI:`LDCR_RATE_LO];
    assign drv3_coarse_current_out = cfg3_reg[`LDCR_COARSE_HI:`LDCR_COARSE_LO];
    assign drv1_strength_select_out = cfg1_reg[`LDCR_STRENGTH_BIT];
    assign drv1_edge_rate_out = cfg1_reg[`LDCR_RATE_HI:`LDCR_RATE_LO];
    assign drv1_coarse_current_out = cfg1_reg[`LDCR_COARSE_HI:`LDCR_COARSE_LO];

    // peak target in units of 1e-6 mA: coarse x100, fine x1000, scale x10
    assign coarse3_w = `LDCR_COARSE_BASE + `LDCR_COARSE_STEP * {26'h000_0000, drv3_coarse_current_out};
    assign fine3_w = `LDCR_FINE_BASE + `LDCR_FINE_STEP * {25'h000_0000, drv3_fine_current_in};
    assign scale3_w = `LDCR_SCALE_BASE + `LDCR_SCALE_STEP * {29'h0000_0000, drv3_strength_select_out};
    assign coarse1_w = `LDCR_COARSE_BASE + `LDCR_COARSE_STEP * {26'h000_0000, drv1_coarse_current_out};
    assign fine1_w = `LDCR_FINE_BASE + `LDCR_FINE_STEP * {25'h000_0000, drv1_fine_current_in};
    assign scale1_w = `LDCR_SCALE_BASE + `LDCR_SCALE_STEP * {29'h0000_0000, drv1_strength_select_out};

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            drv3_peak_target_out <= 30'h0000_0000;
            drv1_peak_target_out <= 30'h0000_0000;
        end
        else
        begin
            drv3_peak_target_out <= coarse3_w * fine3_w * scale3_w;
            drv1_peak_target_out <= coarse1_w * fine1_w * scale1_w;
        end
    end
endmodule

// ==== tb/ldcr_checker.sv ====
// assertions on the ports of the led driver configuration block
`timescale 1ns/1ps
module ldcr_checker (
    input wire clk_in,
    input wire srst_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire [4:0] drv3_fine_current_in,
    input wire [4:0] drv1_fine_current_in,
    input wire drv3_strength_select_out,
    input wire [2:0] drv3_edge_rate_out,
    input wire [3:0] drv3_coarse_current_out,
    input wire drv1_strength_select_out,
    input wire [2:0] drv1_edge_rate_out,
    input wire [3:0] drv1_coarse_current_out,
    input wire [29:0] drv3_peak_target_out,
    input wire [29:0] drv1_peak_target_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    property p_peak3;
        !$past(srst_in) |-> drv3_peak_target_out == (2800 + 1546 * $past(drv3_coarse_current_out))
            * (710 + 24 * $past(drv3_fine_current_in)) * (4 + 6 * $past(drv3_strength_select_out));
    endproperty
    a_peak3: assert property (p_peak3) else $error("drv3 peak target wrong");
    property p_peak1;
        !$past(srst_in) |-> drv1_peak_target_out == (2800 + 1546 * $past(drv1_coarse_current_out))
            * (710 + 24 * $past(drv1_fine_current_in)) * (4 + 6 * $past(drv1_strength_select_out));
    endproperty
    a_peak1: assert property (p_peak1) else $error("drv1 peak target wrong");
    property p_rst3;
        $fell(srst_in) |-> drv3_strength_select_out && drv3_edge_rate_out == 0 && drv3_coarse_current_out == 0;
    endproperty
    a_rst3: assert property (p_rst3) else $error("drv3 reset value wrong");
    property p_rst1;
        $fell(srst_in) |-> drv1_strength_select_out && drv1_edge_rate_out == 0 && drv1_peak_target_out == 0;
    endproperty
    a_rst1: assert property (p_rst1) else $error("drv1 reset value wrong");
    property p_upd3;
        $changed({drv3_edge_rate_out, drv3_coarse_current_out}) |-> ##[0:12] sda_oe_out;
    endproperty
    a_upd3: assert property (p_upd3) else $error("drv3 changed outside a write");
    property p_upd1;
        $changed({drv1_strength_select_out, drv1_edge_rate_out}) |-> ##[0:12] sda_oe_out;
    endproperty
    a_upd1: assert property (p_upd1) else $error("drv1 changed outside a write");
    property p_sda;
        sda_out == 1'b0;
    endproperty
    a_sda: assert property (p_sda) else $error("data pin driven high");
    property p_ack;
        $rose(sda_oe_out) |-> sda_oe_out [*4];
    endproperty
    a_ack: assert property (p_ack) else $error("data pull released too early");
endmodule
bind ldcr_top ldcr_checker u_chk (.clk_in, .srst_in, .sda_out, .sda_oe_out, .drv3_fine_current_in,
    .drv1_fine_current_in, .drv3_strength_select_out, .drv3_edge_rate_out, .drv3_coarse_current_out,
    .drv1_strength_select_out, .drv1_edge_rate_out, .drv1_coarse_current_out, .drv3_peak_target_out,
    .drv1_peak_target_out);

// ==== tb/ldcr_led_model.sv ====
// behavioural emitter load following its peak current target
`timescale 1ns/1ps
module ldcr_led_model (
    input wire clk_in,
    input wire srst_in,
    input wire [29:0] peak_in,
    output reg [29:0] sink_out
);
    always @(posedge clk_in)
    begin
        sink_out <= srst_in ? 30'h0000_0000 : peak_in;
    end
endmodule

// ==== tb/led_driver_config_regs_tb.sv ====
// register bench for the led driver configuration block
`timescale 1ns/1ps
`include "ldcr_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module led_driver_config_regs_tb;
    logic clk_in = 0, srst_in = 1, scl = 1, sda_m = 1, oe, s3, s1;
    logic [4:0] fine3 = 5'h00, fine1 = 5'h1f;
    logic [2:0] r3, r1;
    logic [3:0] c3, c1;
    logic [29:0] p3, p1, k3, k1;
    int error_cnt = 0, checks_done = 0;
    wire sda_in = sda_m & ~oe;
    always #2.5 clk_in = ~clk_in;
    ldcr_top DUT (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda_in), .sda_out(), .sda_oe_out(oe),
        .drv3_fine_current_in(fine3), .drv1_fine_current_in(fine1), .drv3_strength_select_out(s3),
        .drv3_edge_rate_out(r3), .drv3_coarse_current_out(c3), .drv1_strength_select_out(s1),
        .drv1_edge_rate_out(r1), .drv1_coarse_current_out(c1), .drv3_peak_target_out(p3), .drv1_peak_target_out(p1));
    ldcr_led_model led3 (.clk_in(clk_in), .srst_in(srst_in), .peak_in(p3), .sink_out(k3));
    ldcr_led_model led1 (.clk_in(clk_in), .srst_in(srst_in), .peak_in(p1), .sink_out(k1));
    function automatic int pk(input int c, input int f, input int s);
        return (2800 + 1546 * c) * (710 + 24 * f) * (4 + 6 * s);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        tick(5);
        scl = 1;
        tick(5);
        r = sda_in;
        tick(5);
        scl = 0;
        tick(5);
    endtask
    task automatic xfer(input [7:0] d, input logic last, output [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(last, a);
    endtask
    task automatic send(input [7:0] d);
        logic [7:0] r;
        logic a;
        xfer(d, 1'b1, r, a);
        `CHK(a, 1'b0)
    endtask
    task automatic start;
        sda_m = 1;
        tick(5);
        scl = 1;
        tick(10);
        sda_m = 0;
        tick(10);
        scl = 0;
        tick(5);
    endtask
    task automatic stop;
        sda_m = 0;
        tick(5);
        scl = 1;
        tick(10);
        sda_m = 1;
        tick(10);
    endtask
    task automatic wr(input [7:0] p, input [31:0] v, input int n);
        start;
        send({`LDCR_I2C_ADDR, 1'b0});
        send(p);
        for (int i = 0; i < n; i++)
        begin
            send(v[31 - 16 * i -: 8]);
            send(v[23 - 16 * i -: 8]);
        end
        stop;
    endtask
    task automatic rd(input [7:0] p, output [15:0] v);
        logic a;
        start;
        send({`LDCR_I2C_ADDR, 1'b0});
        send(p);
        start;
        send({`LDCR_I2C_ADDR, 1'b1});
        xfer(8'hff, 1'b0, v[15:8], a);
        xfer(8'hff, 1'b1, v[7:0], a);
        stop;
    endtask
    task automatic verify(input [15:0] v3, input [15:0] v1);
        logic [15:0] r;
        rd(`LDCR_ADDR_DRV3, r);
        `CHK(r, v3)
        rd(`LDCR_ADDR_DRV1, r);
        `CHK(r, v1)
        `CHK({s3, r3, c3}, {v3[13], v3[6:0]})
        `CHK({s1, r1, c1}, {v1[13], v1[6:0]})
        `CHK(k3, 30'(pk(v3[3:0], fine3, v3[13])))
        `CHK(k1, 30'(pk(v1[3:0], fine1, v1[13])))
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        logic [15:0] r;
        tick(12);
        srst_in = 0;
        tick(3);
        verify(16'h3000, 16'h3000);
        fine3 = 5'h11;
        wr(`LDCR_ADDR_DRV3, 32'h2075_104f, 2);
        verify(16'h2075, 16'h104f);
        for (int i = 0; i < 8; i++)
        begin
            wr(`LDCR_ADDR_DRV3, {4'h1, 5'h00, 3'(i), 4'(15 - i), 4'h3, 5'h00, 3'(7 - i), 4'(i)}, 2);
            verify({4'h1, 5'h00, 3'(i), 4'(15 - i)}, {4'h3, 5'h00, 3'(7 - i), 4'(i)});
        end
        wr(8'h30, 32'hffff_0000, 1);
        rd(8'h30, r);
        `CHK(r, 16'h0000)
        complete_run;
    end
    initial
    begin
        #400_000;
        error_cnt++;
        complete_run;
    end
endmodule
